/* qdec_pkg.sv */
// Purpose: Shared constants and types of the quadrature encoder decoder.
// Assumes: APB slave with 32-bit data, one word per register.
// Notes: Offsets are byte addresses.
`default_nettype none
package qdec_pkg;
  localparam logic [11:0] OFS_CTL = 12'h000;
  localparam logic [11:0] OFS_STAT = 12'h004;
  localparam logic [11:0] OFS_POS = 12'h008;
  localparam logic [11:0] OFS_MAXPOS = 12'h00C;
  localparam logic [11:0] OFS_LOAD = 12'h010;
  localparam logic [11:0] OFS_TIME = 12'h014;
  localparam logic [11:0] OFS_COUNT = 12'h018;
  localparam logic [11:0] OFS_SPEED = 12'h01C;
  localparam logic [11:0] OFS_INTEN = 12'h020;
  localparam logic [11:0] OFS_RIS = 12'h024;
  localparam logic [11:0] OFS_ISC = 12'h028;
  localparam int CTL_WIDTH = 13;
  localparam int IRQ_WIDTH = 4;
  localparam int IRQ_INDEX = 0;
  localparam int IRQ_TIMER = 1;
  localparam int IRQ_DIR = 2;
  localparam int IRQ_ERROR = 3;
  localparam int STAT_ERROR = 0;
  localparam int STAT_DIR = 1;
  localparam int SYNC_STAGES = 2;
  localparam int PRESCALE_BITS = 7;
  localparam logic [31:0] WORD_RESET = 32'h0000_0000;
  localparam logic [3:0] IRQ_RESET = 4'h0;
  localparam logic [6:0] PRESCALE_RESET = 7'h00;

  // Control word, bit 12 down to bit 0.
  typedef struct packed {
    logic stall_on_halt;
    logic invert_index;
    logic invert_phase_b;
    logic invert_phase_a;
    logic [2:0] velocity_prescale;
    logic velocity_enable;
    logic position_reset_select;
    logic edge_capture_select;
    logic signal_mode_select;
    logic swap_phases;
    logic module_enable;
  } qdec_ctl_t;

  localparam qdec_ctl_t CTL_RESET = 13'h0000;

  // One decoded event of the encoder inputs in a cycle.
  typedef struct packed {
    logic step;
    logic forward;
    logic dir_change;
    logic phase_error;
    logic index;
  } qdec_evt_t;
endpackage
`default_nettype wire

/* qdec_top.sv */
// Purpose: Quadrature or step/direction decoder with position and velocity capture.
// Assumes: Encoder pins are asynchronous and are synchronised here.
// Notes: APB answers with no wait state; irq is registered.
//
// Implementation choices: the APB register port and the register offsets.
`default_nettype none
// How it works
// - Separate position and velocity enables, velocity needs position
// - Swap exchanges phases, reversing count sense in quadrature mode
// - Mode bit: quadrature at zero, else step/direction
// - Step mode: phase A steps, phase B direction
// - Capture select: A edges only, or both
// - A leading counts up, B leading down
// - Same phase edge twice flags direction change
// - Reset select zero: index clears position
// - Reverse step from zero loads the limit
// - Reset select one: wrap at limit, ignore index
// - Position is absolute after an index
// - Velocity counts the same edges as position
// - Timer counts down, reloads at zero, interrupts
// - Prescaler divides velocity edges by power two
// - Maskable interrupts with raw, masked and clear
// - Decoding starts only after module enable
// - Prescale field bits 8:6, ratio 1 to 128
// - Invert bits for phase A, B and index
// - Stall bit freezes counting during debug halt
module qdec_top (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Encoder pins and debug halt.
  input wire logic phase_a_input,
  input wire logic phase_b_input,
  input wire logic index_input,
  input wire logic debug_halt,
  // Interrupt.
  output logic irq
);
  logic [2:0] pin_raw;
  logic [2:0] sync_ff [qdec_pkg::SYNC_STAGES];
  logic [2:0] prev_ff;
  qdec_pkg::qdec_ctl_t ctl_ff;
  logic [31:0] pos_ff;
  logic [31:0] maxpos_ff;
  logic [31:0] load_ff;
  logic [31:0] time_ff;
  logic [31:0] count_ff;
  logic [31:0] speed_ff;
  logic [qdec_pkg::IRQ_WIDTH-1:0] inten_ff;
  logic [qdec_pkg::IRQ_WIDTH-1:0] ris_ff;
  logic [qdec_pkg::PRESCALE_BITS-1:0] pre_ff;
  logic dir_ff;
  logic err_ff;
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic irq_ff;
  logic [2:0] cur;
  logic [2:0] old;
  logic a_edge;
  logic b_edge;
  logic active;
  logic vel_active;
  qdec_pkg::qdec_evt_t evt;
  logic vel_pulse;
  logic [qdec_pkg::PRESCALE_BITS-1:0] pre_mask;
  logic [qdec_pkg::IRQ_WIDTH-1:0] irq_set;
  logic wr_en;
  logic [31:0] rd_mux;
  logic rd_hit;
  logic [2:0] inv_mask;
  logic halted;
  logic index_rise;
  logic step_rise;

  assign pin_raw = {index_input, phase_b_input, phase_a_input};

  // The first stage is read only by the second, so a metastable sample never reaches the decoder.
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sync
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sync_ff[0][gi] <= 1'b0;
          sync_ff[1][gi] <= 1'b0;
          prev_ff[gi] <= 1'b0;
        end else begin
          sync_ff[0][gi] <= pin_raw[gi];
          sync_ff[1][gi] <= sync_ff[0][gi];
          prev_ff[gi] <= sync_ff[1][gi];
        end
      end
    end
  endgenerate

  // Inversion first, then the swap, on both the new and the old sample.
  // Both samples flip together, so changing an invert bit never makes a false edge.
  assign inv_mask = {ctl_ff.invert_index, ctl_ff.invert_phase_b, ctl_ff.invert_phase_a};
  always_comb begin
    cur = sync_ff[1] ^ inv_mask;
    old = prev_ff ^ inv_mask;
    if (ctl_ff.swap_phases) begin
      cur = {cur[2], cur[0], cur[1]};
      old = {old[2], old[0], old[1]};
    end
  end

  assign a_edge = cur[0] ^ old[0];
  assign b_edge = cur[1] ^ old[1];
  // A debug halt with the stall bit set freezes every counter of the block.
  assign halted = ctl_ff.stall_on_halt && debug_halt;
  assign active = ctl_ff.module_enable && !halted;
  assign index_rise = cur[2] && !old[2];
  assign step_rise = cur[0] && !old[0];
  assign vel_active = active && ctl_ff.velocity_enable;

  always_comb begin
    evt = '0;
    if (active) begin
      evt.index = index_rise;
      // The stored direction is 1 for backward, so a change is a decoded sense that differs from it.
      if (ctl_ff.signal_mode_select) begin
        evt.step = step_rise;
        evt.forward = !cur[1];
        evt.dir_change = evt.step && ((!evt.forward) != dir_ff);
      end else if (a_edge && b_edge) begin
        evt.phase_error = 1'b1;
      end else if (a_edge || b_edge) begin
        evt.forward = cur[0] ^ old[1];
        evt.step = a_edge || ctl_ff.edge_capture_select;
        evt.dir_change = (!evt.forward) != dir_ff;
      end
    end
  end

  // The velocity edge falls on the last step of each group of 2^n steps.
  assign pre_mask = qdec_pkg::PRESCALE_BITS'((8'h01 << ctl_ff.velocity_prescale) - 8'h01);
  assign vel_pulse = vel_active && evt.step && ((pre_ff & pre_mask) == pre_mask);

  assign wr_en = psel && penable && pready_ff && pwrite;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_ff <= qdec_pkg::CTL_RESET;
      maxpos_ff <= qdec_pkg::WORD_RESET;
      load_ff <= qdec_pkg::WORD_RESET;
      inten_ff <= qdec_pkg::IRQ_RESET;
    end else if (wr_en) begin
      case (paddr)
        qdec_pkg::OFS_CTL: ctl_ff <= pwdata[qdec_pkg::CTL_WIDTH-1:0];
        qdec_pkg::OFS_MAXPOS: maxpos_ff <= pwdata;
        qdec_pkg::OFS_LOAD: load_ff <= pwdata;
        qdec_pkg::OFS_INTEN: inten_ff <= pwdata[qdec_pkg::IRQ_WIDTH-1:0];
        default: ctl_ff <= ctl_ff;
      endcase
    end
  end

  // Position: index clear wins over a step in the same cycle; a software write wins over both.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos_ff <= qdec_pkg::WORD_RESET;
    end else if (wr_en && paddr == qdec_pkg::OFS_POS) begin
      pos_ff <= pwdata;
    end else if (evt.index && !ctl_ff.position_reset_select) begin
      pos_ff <= qdec_pkg::WORD_RESET;
    end else if (evt.step) begin
      if (evt.forward) begin
        pos_ff <= (pos_ff >= maxpos_ff) ? qdec_pkg::WORD_RESET : pos_ff + 32'h0000_0001;
      end else begin
        pos_ff <= (pos_ff == 32'h0000_0000) ? maxpos_ff : pos_ff - 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir_ff <= 1'b0;
      err_ff <= 1'b0;
    end else begin
      if (evt.step || evt.dir_change) begin
        dir_ff <= !evt.forward;
      end
      // The error flag shows the latest decode: the next valid step clears it.
      if (evt.phase_error) begin
        err_ff <= 1'b1;
      end else if (evt.step) begin
        err_ff <= 1'b0;
      end
    end
  end

  // Velocity timer and accumulator run only while velocity capture is on.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      time_ff <= qdec_pkg::WORD_RESET;
      count_ff <= qdec_pkg::WORD_RESET;
      speed_ff <= qdec_pkg::WORD_RESET;
      pre_ff <= qdec_pkg::PRESCALE_RESET;
    end else if (!vel_active) begin
      // A stall keeps the period and the count; turning capture off restarts both.
      if (!ctl_ff.velocity_enable) begin
        time_ff <= load_ff;
        count_ff <= qdec_pkg::WORD_RESET;
        pre_ff <= qdec_pkg::PRESCALE_RESET;
      end
    end else begin
      if (evt.step) begin
        pre_ff <= pre_ff + 7'h01;
      end
      // Reloading in the zero cycle makes each period one cycle longer than the load value.
      if (time_ff == 32'h0000_0000) begin
        time_ff <= load_ff;
        speed_ff <= count_ff + {31'h0000_0000, vel_pulse};
        count_ff <= qdec_pkg::WORD_RESET;
      end else begin
        time_ff <= time_ff - 32'h0000_0001;
        if (vel_pulse) begin
          count_ff <= count_ff + 32'h0000_0001;
        end
      end
    end
  end

  always_comb begin
    irq_set = '0;
    irq_set[qdec_pkg::IRQ_INDEX] = evt.index;
    irq_set[qdec_pkg::IRQ_TIMER] = vel_active && (time_ff == 32'h0000_0000);
    irq_set[qdec_pkg::IRQ_DIR] = evt.dir_change;
    irq_set[qdec_pkg::IRQ_ERROR] = evt.phase_error;
  end

  // A new event in the cycle of its write-one clear keeps the flag set.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ris_ff <= qdec_pkg::IRQ_RESET;
      irq_ff <= 1'b0;
    end else begin
      if (wr_en && paddr == qdec_pkg::OFS_ISC) begin
        ris_ff <= (ris_ff & ~pwdata[qdec_pkg::IRQ_WIDTH-1:0]) | irq_set;
      end else begin
        ris_ff <= ris_ff | irq_set;
      end
      irq_ff <= |(ris_ff & inten_ff);
    end
  end

  // Unmapped and misaligned addresses answer with an error and read as zero.
  always_comb begin
    rd_mux = qdec_pkg::WORD_RESET;
    rd_hit = 1'b1;
    case (paddr)
      qdec_pkg::OFS_CTL: rd_mux = {19'h0_0000, ctl_ff};
      qdec_pkg::OFS_STAT: begin
        rd_mux[qdec_pkg::STAT_ERROR] = err_ff;
        rd_mux[qdec_pkg::STAT_DIR] = dir_ff;
      end
      qdec_pkg::OFS_POS: rd_mux = pos_ff;
      qdec_pkg::OFS_MAXPOS: rd_mux = maxpos_ff;
      qdec_pkg::OFS_LOAD: rd_mux = load_ff;
      qdec_pkg::OFS_TIME: rd_mux = time_ff;
      qdec_pkg::OFS_COUNT: rd_mux = count_ff;
      qdec_pkg::OFS_SPEED: rd_mux = speed_ff;
      qdec_pkg::OFS_INTEN: rd_mux = {28'h000_0000, inten_ff};
      qdec_pkg::OFS_RIS: rd_mux = {28'h000_0000, ris_ff};
      qdec_pkg::OFS_ISC: rd_mux = {28'h000_0000, ris_ff & inten_ff};
      default: rd_hit = 1'b0;
    endcase
  end

  // The answer is prepared in the setup cycle so the access phase never waits.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= qdec_pkg::WORD_RESET;
    end else begin
      pready_ff <= psel && !penable;
      pslverr_ff <= psel && !penable && !rd_hit;
      if (psel && !penable && !pwrite) begin
        prdata_ff <= rd_mux;
      end
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign irq = irq_ff;
endmodule // qdec_top
`default_nettype wire

/* qdec_top_end.sv */
`default_nettype none
`default_nettype wire

/* qdec_assertions.sv */
// Purpose: Checker of APB answers and the interrupt line.
// Assumes: Zero-wait slave.
// Notes: Sees top ports only.
`default_nettype none
module qdec_assertions (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Interrupt.
  input wire logic irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence setup_s; psel && !penable; endsequence
  sequence bad_s; setup_s ##0 paddr > qdec_pkg::OFS_ISC; endsequence
  setup_answer_a: assert property (setup_s |=> pready) else $error("no answer");
  ready_pulse_a: assert property (pready |=> !pready) else $error("long ready");
  err_unmapped_a: assert property (bad_s |=> pslverr) else $error("no error");
  err_mapped_a: assert property (setup_s ##0 (paddr <= qdec_pkg::OFS_ISC && paddr[1:0] == 2'h0)
    |=> !pslverr) else $error("false error");
  err_with_ready_a: assert property (pslverr |-> pready) else $error("stray error");
  rdata_hold_a: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
    else $error("read data moved");
  bad_rdata_a: assert property (bad_s ##0 !pwrite |=> prdata == 32'h0000_0000)
    else $error("unmapped data");
  irq_release_a: assert property ($rose(presetn) |-> !irq && !pready) else $error("early irq");
endmodule // qdec_assertions
`default_nettype wire

/* qdec_enc_model.sv */
// Purpose: Behavioural incremental encoder.
// Assumes: Pins move after a rising edge.
// Notes: A five-cycle rest covers the synchroniser.
`default_nettype none
module qdec_enc_model (
  // Clock.
  input wire logic clk,
  // Encoder pins.
  output logic a,
  output logic b,
  output logic idx
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] ph = 2'h0;
  initial begin
    a = 1'b0;
    b = 1'b0;
    idx = 1'b0;
  end
  task automatic rest();
    repeat (5) @(posedge clk);
  endtask
  // Phase a leads on forward moves.
  task automatic step(input logic fwd);
    @(posedge clk);
    ph = fwd ? ph + 2'h1 : ph - 2'h1;
    a <= ph[1] ^ ph[0];
    b <= ph[1];
    rest();
  endtask
  task automatic both();
    @(posedge clk);
    ph = ph + 2'h2;
    a <= !a;
    b <= !b;
    rest();
  endtask
  // Direction is set well before the step edge.
  task automatic pulse(input logic fwd);
    @(posedge clk);
    b <= !fwd;
    repeat (3) @(posedge clk);
    a <= 1'b1;
    repeat (3) @(posedge clk);
    a <= 1'b0;
    rest();
  endtask
  task automatic mark();
    @(posedge clk);
    idx <= 1'b1;
    repeat (3) @(posedge clk);
    idx <= 1'b0;
    rest();
  endtask
endmodule // qdec_enc_model
`default_nettype wire

/* qdec_top_tb_top.sv */
// Purpose: Self-checking bench of the decoder.
// Assumes: Zero-wait APB.
// Notes: Register rows, then hand-written cases.
`default_nettype none
module qdec_top_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [11:0] a;
    logic [31:0] w;
    logic [31:0] e;
  } qdec_row_t;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, halt = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, q;
  logic pready, pslverr, irq, pa, pb, pi;
  int mismatches = 0, n_compared = 0, cyc = 0;
  qdec_row_t rows [7] = '{'{qdec_pkg::OFS_CTL, 32'hFFFF_FFFE, 32'h0000_1FFE},
    '{qdec_pkg::OFS_MAXPOS, 32'h0000_0F9F, 32'h0000_0F9F}, '{qdec_pkg::OFS_LOAD, 32'h0000_1234, 32'h0000_1234},
    '{qdec_pkg::OFS_INTEN, 32'hFFFF_FFFF, 32'h0000_000F}, '{qdec_pkg::OFS_STAT, 32'hFFFF_FFFF, 32'h0000_0000},
    '{qdec_pkg::OFS_SPEED, 32'hFFFF_FFFF, 32'h0000_0000}, '{12'h02C, 32'hFFFF_FFFF, 32'h0000_0000}};
  always #25 pclk = ~pclk;
  qdec_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .phase_a_input(pa), .phase_b_input(pb), .index_input(pi), .debug_halt(halt), .irq(irq));
  qdec_enc_model enc (.clk(pclk), .a(pa), .b(pb), .idx(pi));
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  // The request stands until pready is sampled high.
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rc(input logic [11:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0000_0000);
    chk(q, e);
  endtask
  task automatic pc(input logic [31:0] e);
    rc(qdec_pkg::OFS_POS, e);
  endtask
  // Position and flags clear while decoding is off, so no stray count.
  task automatic cfg(input logic [31:0] c);
    xfer(1'b1, qdec_pkg::OFS_CTL, 32'h0000_0000);
    xfer(1'b1, qdec_pkg::OFS_POS, 32'h0000_0000);
    xfer(1'b1, qdec_pkg::OFS_ISC, 32'h0000_000F);
    xfer(1'b1, qdec_pkg::OFS_CTL, c);
  endtask
  task automatic mv(input logic fwd, input int n);
    repeat (n) enc.step(fwd);
  endtask
  task automatic test_done();
    $display("Compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      test_done();
    end
  end
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i]) begin
      rc(rows[i].a, 32'h0000_0000);
      xfer(1'b1, rows[i].a, rows[i].w);
      rc(rows[i].a, rows[i].e);
    end
    xfer(1'b1, qdec_pkg::OFS_MAXPOS, 32'h0000_0003);
    cfg(32'h0000_0009);
    mv(1'b1, 5);
    pc(32'h0000_0001);
    mv(1'b0, 2);
    pc(32'h0000_0003);
    rc(qdec_pkg::OFS_RIS, 32'h0000_0004);
    enc.mark();
    pc(32'h0000_0000);
    rc(qdec_pkg::OFS_RIS, 32'h0000_0005);
    cfg(32'h0000_0019);
    mv(1'b1, 2);
    enc.mark();
    pc(32'h0000_0002);
    cfg(32'h0000_0001);
    mv(1'b1, 4);
    pc(32'h0000_0002);
    cfg(32'h0000_000B);
    mv(1'b1, 1);
    pc(32'h0000_0003);
    cfg(32'h0000_0209);
    mv(1'b1, 3);
    pc(32'h0000_0001);
    mv(1'b1, 1);
    pc(32'h0000_0000);
    cfg(32'h0000_0008);
    mv(1'b1, 2);
    pc(32'h0000_0000);
    cfg(32'h0000_1009);
    halt <= 1'b1;
    mv(1'b1, 2);
    pc(32'h0000_0000);
    halt <= 1'b0;
    cfg(32'h0000_0009);
    xfer(1'b1, qdec_pkg::OFS_INTEN, 32'h0000_0008);
    enc.both();
    rc(qdec_pkg::OFS_RIS, 32'h0000_0008);
    chk({31'h0000_0000, irq}, 32'h0000_0001);
    // A period of 200 cycles holds all eight edges.
    xfer(1'b1, qdec_pkg::OFS_LOAD, 32'h0000_00C7);
    xfer(1'b1, qdec_pkg::OFS_INTEN, 32'h0000_0002);
    cfg(32'h0000_00A9);
    mv(1'b1, 8);
    repeat (200) @(posedge pclk);
    rc(qdec_pkg::OFS_SPEED, 32'h0000_0002);
    rc(qdec_pkg::OFS_RIS, 32'h0000_0006);
    chk({31'h0000_0000, irq}, 32'h0000_0001);
    xfer(1'b1, qdec_pkg::OFS_INTEN, 32'h0000_0000);
    rc(qdec_pkg::OFS_ISC, 32'h0000_0000);
    xfer(1'b1, qdec_pkg::OFS_ISC, 32'h0000_0002);
    rc(qdec_pkg::OFS_RIS, 32'h0000_0004);
    repeat (200) @(posedge pclk);
    rc(qdec_pkg::OFS_SPEED, 32'h0000_0000);
    cfg(32'h0000_0020);
    repeat (20) @(posedge pclk);
    rc(qdec_pkg::OFS_TIME, 32'h0000_00C7);
    cfg(32'h0000_0005);
    enc.pulse(1'b1);
    enc.pulse(1'b1);
    pc(32'h0000_0002);
    enc.pulse(1'b0);
    pc(32'h0000_0001);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rc(qdec_pkg::OFS_CTL, 32'h0000_0000);
    test_done();
  end
endmodule // qdec_top_tb_top
bind qdec_top qdec_assertions chk_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));
`default_nettype wire
